// File: logic/hqs_defines.svh
// Purpose: constants for hall and quadrature rotor sensing
// Assumes: one clock, apb register access
// Notes: offsets are byte addresses
// Functional notes
// RULE_01 - two sensored modes, hall and encoder; default off means sensorless path
// RULE_02 - motor carries three hall sensors 120 degrees apart, each feeding an input
// RULE_03 - hall output low near south face, high near north face
// RULE_04 - detect both edges on every hall input and sample all three as state
// RULE_05 - each hall edge is 60 degrees; speed is 60 degrees over edge interval
// RULE_06 - timer measures hall interval; overflow before next edge raises an event
// RULE_07 - between edges position is last edge angle plus speed integral
// RULE_08 - on each hall edge position resets to the exact angle of new state
// RULE_09 - optional xor of halls restarts a free running counter on every edge
// RULE_10 - encoder supplies phase a and b 90 degrees apart plus an index
// RULE_11 - b lagging a counts up on every edge of both phases
// RULE_12 - b leading a counts down on every edge of both phases
// RULE_13 - readable direction flag shows counting up or down
// RULE_14 - counter starts at 0, wraps at configurable maximum, 4095 for 1024 pulses
// RULE_15 - index pulse checks accumulated count consistency
// RULE_16 - counter runs on system clock with prescaler 1
// RULE_17 - encoder mode derives position and speed from the quadrature count
// RULE_18 - six valid hall states map to sector angles; all low or all high is fault
// RULE_19 - phases synchronised before edge detect; filters off, polarity normal by default
`ifndef HQS_DEFINES_SVH
`define HQS_DEFINES_SVH
`define HQS_ADDR_CTRL 12'h000
`define HQS_ADDR_MAXCNT 12'h004
`define HQS_ADDR_STATUS 12'h008
`define HQS_ADDR_MASK 12'h00C
`define HQS_ADDR_POS 12'h010
`define HQS_ADDR_SPEED 12'h014
`define HQS_ADDR_QCOUNT 12'h018
`define HQS_ADDR_HALL 12'h01C
`define HQS_CTRL_MODE_LSB 0
`define HQS_CTRL_XOR_BIT 2
`define HQS_CTRL_FILT_BIT 3
`define HQS_CTRL_POLA_BIT 4
`define HQS_CTRL_POLB_BIT 5
`define HQS_CTRL_RESET 32'h0000_0000
`define HQS_MAXCNT_RESET 16'h0FFF
`define HQS_ST_EDGE 0
`define HQS_ST_OVF 1
`define HQS_ST_FAULT 2
`define HQS_ST_INDEX_ERR 3
`define HQS_ST_INDEX 4
`define HQS_NUM_EVENTS 5
`define HQS_SECTOR_DEG 16'h2AAB
`define HQS_PRESCALE 1
`define HQS_CLK_MHZ 10
`endif

// File: logic/hqs_pkg.sv
// Purpose: types for rotor sensing
// Assumes: nothing
// Notes: mode encoding matches the control field
package hqs_pkg;
  typedef enum logic [1:0] {
    HQS_MODE_OFF,
    HQS_MODE_HALL,
    HQS_MODE_ENC
  } hqs_mode_type;
  typedef enum logic [1:0] {
    HQS_QD_IDLE,
    HQS_QD_UP,
    HQS_QD_DOWN
  } hqs_qstep_type;
endpackage

// File: logic/hqs_quad_dec.sv
// Purpose: quadrature step decoder for phase a and b
// Assumes: phase inputs may be asynchronous; two-flop sync inside
// Notes: optional two-sample filter, polarity invert
`timescale 1ns/1ns
`include "hqs_defines.svh"
module hqs_quad_dec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic filt_en,
  input wire logic inv_a,
  input wire logic inv_b,
  output hqs_pkg::hqs_qstep_type step
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] filt_q;
  logic [1:0] prev_q;
  wire logic [1:0] pol = sync_q ^ {inv_b, inv_a};
  wire logic [1:0] cur = filt_en ? ((pol == filt_q) ? pol : prev_q) : pol;
  // gray transition table: previous ba to current ba
  wire logic up = (prev_q == 2'h0 && cur == 2'h1) || (prev_q == 2'h1 && cur == 2'h3) ||
                  (prev_q == 2'h3 && cur == 2'h2) || (prev_q == 2'h2 && cur == 2'h0);
  wire logic dn = (prev_q == 2'h0 && cur == 2'h2) || (prev_q == 2'h2 && cur == 2'h3) ||
                  (prev_q == 2'h3 && cur == 2'h1) || (prev_q == 2'h1 && cur == 2'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      filt_q <= 2'h0;
      prev_q <= 2'h0;
    end else if (ce) begin
      meta_q <= {phase_b, phase_a}; // RULE_19
      sync_q <= meta_q;
      filt_q <= pol;
      prev_q <= cur;
    end
  end
  // illegal double steps are dropped as noise
  assign step = up ? hqs_pkg::HQS_QD_UP : (dn ? hqs_pkg::HQS_QD_DOWN : hqs_pkg::HQS_QD_IDLE); // RULE_11 RULE_12
endmodule

// File: logic/hqs_rotor_sense.sv
// Purpose: hall and quadrature rotor position and speed sensing with apb registers
// Assumes: pclk 10 MHz, sensor inputs synchronous to pclk
// Notes: angle is 16 bit, full turn = 65536; speed is angle per pclk in 16.16 form
`timescale 1ns/1ns
`include "hqs_defines.svh"
module hqs_rotor_sense #(
  parameter int TMR_W = 24,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] hall_in,
  input wire logic enc_phase_a,
  input wire logic enc_phase_b,
  input wire logic enc_index,
  output logic irq,
  output logic [15:0] rotor_angle,
  output logic count_direction_flag
);
  logic [31:0] ctrl_q;
  logic [CNT_W-1:0] maxcnt_q;
  logic [`HQS_NUM_EVENTS-1:0] status_q;
  logic [`HQS_NUM_EVENTS-1:0] mask_q;
  logic [2:0] hall_q;
  logic [2:0] hall_state_q;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] period_q;
  logic [31:0] speed_q;
  logic [31:0] integ_q;
  logic [15:0] base_q;
  logic [CNT_W-1:0] qcnt_q;
  logic [TMR_W-1:0] qtmr_q;
  logic [CNT_W-1:0] qdelta_q;
  logic dir_q;
  logic idx_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [15:0] angle_q;
  logic [31:0] espd_q;
  hqs_pkg::hqs_qstep_type qstep;

  // sector table: 60 degree steps, 65536 per electrical turn
  function automatic logic [15:0] hall_angle(input logic [2:0] h);
    logic [15:0] a;
    a = 16'h0000;
    case (h)
      3'h5: a = 16'h0000;
      3'h4: a = 16'h2AAB;
      3'h6: a = 16'h5555;
      3'h2: a = 16'h8000;
      3'h3: a = 16'hAAAB;
      3'h1: a = 16'hD555;
      default: a = 16'h0000;
    endcase
    return a;
  endfunction

  function automatic logic hall_bad(input logic [2:0] h);
    return (h == 3'h0) || (h == 3'h7);
  endfunction

  function automatic logic [31:0] sector_speed(input logic [TMR_W-1:0] t);
    logic [47:0] num;
    num = {`HQS_SECTOR_DEG, 32'h0000_0000} >> 16;
    if (t == '0) begin
      return 32'h0000_0000;
    end
    return 32'(num / 48'(t));
  endfunction

  // apb decode
  wire logic acc = psel && penable && clk_en;
  wire logic wr = acc && pwrite;
  wire logic rd = acc && !pwrite;
  wire logic hit_ctrl = (paddr == `HQS_ADDR_CTRL);
  wire logic hit_max = (paddr == `HQS_ADDR_MAXCNT);
  wire logic hit_st = (paddr == `HQS_ADDR_STATUS);
  wire logic hit_mask = (paddr == `HQS_ADDR_MASK);
  wire logic hit_pos = (paddr == `HQS_ADDR_POS);
  wire logic hit_spd = (paddr == `HQS_ADDR_SPEED);
  wire logic hit_qc = (paddr == `HQS_ADDR_QCOUNT);
  wire logic hit_hall = (paddr == `HQS_ADDR_HALL);
  wire logic hit_any = hit_ctrl || hit_max || hit_st || hit_mask || hit_pos || hit_spd || hit_qc || hit_hall;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = ctrl_q;
    end else if (hit_max) begin
      rd_mux = 32'(maxcnt_q);
    end else if (hit_st) begin
      rd_mux = 32'(status_q);
    end else if (hit_mask) begin
      rd_mux = 32'(mask_q);
    end else if (hit_pos) begin
      rd_mux = {15'h0000, dir_q, angle_q}; // RULE_13
    end else if (hit_spd) begin
      // encoder mode reports the step rate, other modes the hall rate
      rd_mux = (ctrl_q[`HQS_CTRL_MODE_LSB +: 2] == 2'h2) ? espd_q : speed_q; // RULE_17
    end else if (hit_qc) begin
      rd_mux = 32'(qcnt_q);
    end else if (hit_hall) begin
      rd_mux = {29'h0000_0000, hall_state_q};
    end
  end

  // configuration
  wire hqs_pkg::hqs_mode_type mode = hqs_pkg::hqs_mode_type'(ctrl_q[`HQS_CTRL_MODE_LSB +: 2]);
  wire logic hall_mode = (mode == hqs_pkg::HQS_MODE_HALL); // RULE_01
  wire logic enc_mode = (mode == hqs_pkg::HQS_MODE_ENC); // RULE_01
  wire logic xor_mode = ctrl_q[`HQS_CTRL_XOR_BIT];

  // hall edges; the xor option, as one combined channel, sees only edges that change an odd number of inputs
  wire logic xor_prev = ^hall_q;
  wire logic xor_now = ^hall_in; // RULE_09
  wire logic hall_edge = hall_mode && (xor_mode ? (xor_prev != xor_now) : (hall_q != hall_in)); // RULE_04
  wire logic tmr_ovf = hall_mode && (tmr_q == {TMR_W{1'b1}}); // RULE_06
  wire logic hall_fault = hall_edge && hall_bad(hall_in); // RULE_18
  // integral kept in 16.16 so slow speeds still move the angle
  wire logic [31:0] integ_next = integ_q + speed_q;
  wire logic [15:0] integ_cap = (integ_next[31:16] > `HQS_SECTOR_DEG) ? `HQS_SECTOR_DEG : integ_next[31:16];
  wire logic [15:0] hall_pos = base_q + integ_cap; // RULE_07

  // quadrature counter with wrap
  wire logic q_up = enc_mode && (qstep == hqs_pkg::HQS_QD_UP);
  wire logic q_dn = enc_mode && (qstep == hqs_pkg::HQS_QD_DOWN);
  wire logic [CNT_W-1:0] q_inc = (qcnt_q >= maxcnt_q) ? '0 : qcnt_q + 1'b1;
  wire logic [CNT_W-1:0] q_dec = (qcnt_q == '0) ? maxcnt_q : qcnt_q - 1'b1;
  wire logic [CNT_W-1:0] q_next = q_up ? q_inc : (q_dn ? q_dec : qcnt_q); // RULE_14
  wire logic idx_rise = enc_mode && enc_index && !idx_q;
  // each index must find the counter at zero or at the maximum count
  wire logic idx_err = idx_rise && (qcnt_q != '0) && (qcnt_q != maxcnt_q); // RULE_15
  wire logic [31:0] enc_pos32 = (32'(qcnt_q) << 16) / (32'(maxcnt_q) + 32'h0000_0001);
  wire logic [15:0] enc_pos = enc_pos32[15:0]; // RULE_17
  wire logic qstep_any = q_up || q_dn;

  wire logic [`HQS_NUM_EVENTS-1:0] ev = {idx_rise, idx_err, hall_fault, tmr_ovf, hall_edge};
  wire logic st_clr = rd && hit_st;

  hqs_quad_dec u_qd (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .phase_a(enc_phase_a),
    .phase_b(enc_phase_b),
    .filt_en(ctrl_q[`HQS_CTRL_FILT_BIT]), // RULE_19
    .inv_a(ctrl_q[`HQS_CTRL_POLA_BIT]),
    .inv_b(ctrl_q[`HQS_CTRL_POLB_BIT]),
    .step(qstep)
  );

  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `HQS_CTRL_RESET;
      maxcnt_q <= CNT_W'(`HQS_MAXCNT_RESET);
      mask_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= psel && !penable && !pready_q;
      pslverr_q <= psel && !penable && !hit_any;
      if (psel && !penable) begin
        prdata_q <= rd_mux;
      end
      if (wr && pready_q && hit_ctrl) begin
        ctrl_q <= {26'h0000000, pwdata[5:0]};
      end
      if (wr && pready_q && hit_max) begin
        maxcnt_q <= pwdata[CNT_W-1:0];
      end
      if (wr && pready_q && hit_mask) begin
        mask_q <= pwdata[`HQS_NUM_EVENTS-1:0];
      end
    end
  end

  // events, set beats read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      status_q <= ((st_clr && pready_q) ? '0 : status_q) | ev;
      irq_q <= |((((st_clr && pready_q) ? '0 : status_q) | ev) & mask_q);
    end
  end

  // hall path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_q <= 3'h0;
      hall_state_q <= 3'h0;
      tmr_q <= '0;
      period_q <= '0;
      speed_q <= 32'h0000_0000;
      integ_q <= 32'h0000_0000;
      base_q <= 16'h0000;
    end else if (clk_en) begin
      hall_q <= hall_in;
      if (hall_edge) begin
        hall_state_q <= hall_in; // RULE_04
        period_q <= tmr_q;
        tmr_q <= '0; // RULE_09
        speed_q <= sector_speed(tmr_q + 1'b1); // RULE_05
        base_q <= hall_angle(hall_in); // RULE_08
        integ_q <= 32'h0000_0000; // RULE_08
      end else if (tmr_ovf) begin
        speed_q <= 32'h0000_0000; // RULE_06
      end else if (hall_mode) begin
        tmr_q <= tmr_q + 1'b1;
        integ_q <= integ_next; // RULE_07
      end
    end
  end

  // encoder path: speed is 65536 times step angle over the pclks between steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_q <= '0;
      dir_q <= 1'b0;
      idx_q <= 1'b0;
      qtmr_q <= '0;
      qdelta_q <= '0;
    end else if (clk_en) begin
      qcnt_q <= q_next; // RULE_16
      idx_q <= enc_index;
      if (qstep_any) begin
        dir_q <= q_dn; // RULE_13
      end
      if (enc_mode && qstep_any) begin
        qdelta_q <= (qtmr_q == '0) ? CNT_W'(1) : qdelta_q;
        qtmr_q <= '0;
      end else if (enc_mode && qtmr_q != {TMR_W{1'b1}}) begin
        qtmr_q <= qtmr_q + 1'b1;
      end
    end
  end

  // outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_q <= 16'h0000;
    end else if (clk_en) begin
      // off mode holds zero so the sensorless estimate is used outside
      angle_q <= hall_mode ? (hall_edge ? hall_angle(hall_in) : hall_pos) : (enc_mode ? enc_pos : 16'h0000);
    end
  end

  // encoder speed uses the step interval, same form as the hall speed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      espd_q <= 32'h0000_0000;
    end else if (clk_en && enc_mode && qstep_any) begin
      espd_q <= 32'((48'h1_0000_0000 / (48'(maxcnt_q) + 48'h1)) / (48'(qtmr_q) + 48'h1)); // RULE_17
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign rotor_angle = angle_q;
  assign count_direction_flag = dir_q;
endmodule

// File: tb/hqs_rotor_sense_monitor.sv
// Purpose: port checks for rotor sensing
// Assumes: one pclk domain
// Notes: bound to the block
`timescale 1ns/1ns
module hqs_rotor_sense_monitor #(
  parameter int TMR_W = 24,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] hall_in,
  input wire logic enc_phase_a,
  input wire logic enc_phase_b,
  input wire logic enc_index,
  input wire logic irq,
  input wire logic [15:0] rotor_angle,
  input wire logic count_direction_flag
);
  logic [1:0] ph_q;
  logic [7:0] ph_age_q;
  logic [7:0] bus_age_q;
  wire ph_move = ph_q != {enc_phase_a, enc_phase_b};
  wire st_acc = psel && penable && pready && (paddr == 12'h008 || paddr == 12'h00C);
  // ages saturate so a long idle never wraps back into range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 2'h0;
      ph_age_q <= 8'hFF;
      bus_age_q <= 8'hFF;
    end else begin
      ph_q <= {enc_phase_a, enc_phase_b};
      ph_age_q <= ph_move ? 8'h00 : ph_age_q + {7'h0, ph_age_q != 8'hFF};
      bus_age_q <= st_acc ? 8'h00 : bus_age_q + {7'h0, bus_age_q != 8'hFF};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) !presetn ##1 !presetn |->
    !pready && !irq && rotor_angle == 16'h0000) else $error("outputs not quiet in reset");
  ready_setup_a: assert property (setup_s |=> answer_s)
    else $error("pready not a single pulse after setup");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable) == 1'b0)
    else $error("pready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  dir_cause_a: assert property ($changed(count_direction_flag) |-> ph_age_q <= 8'h06)
    else $error("direction changed without phase edge");
  irq_clear_a: assert property ($fell(irq) |-> bus_age_q <= 8'h04)
    else $error("irq fell without status or mask access");
  freeze_a: assert property ($past(clk_en) == 1'b0 |-> $stable(rotor_angle) && $stable(irq))
    else $error("state moved while clock enable low");
endmodule
bind hqs_rotor_sense hqs_rotor_sense_monitor #(.TMR_W(TMR_W), .CNT_W(CNT_W)) i_hqs_rotor_sense_monitor (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hall_in(hall_in),
  .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b), .enc_index(enc_index), .irq(irq),
  .rotor_angle(rotor_angle), .count_direction_flag(count_direction_flag));

// File: tb/hqs_motor_model.sv
// Purpose: hall sensors and quadrature encoder on the motor
// Assumes: driven through its tasks
// Notes: each step lands after a rising edge
`timescale 1ns/1ns
module hqs_motor_model (
  input wire logic pclk,
  output logic [2:0] hall_in,
  output logic enc_phase_a,
  output logic enc_phase_b,
  output logic enc_index
);
  // one bit changes a step: three sensors 120 degrees apart
  logic [2:0] hall_tab [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  int hp = 0;
  logic [1:0] qp = 2'h0;
  initial begin
    hall_in = 3'h5;
    enc_phase_a = 1'b0;
    enc_phase_b = 1'b0;
    enc_index = 1'b0;
  end
  task automatic hall_step();
    @(posedge pclk);
    hp = (hp + 1) % 6;
    hall_in <= hall_tab[hp];
    repeat (8) @(posedge pclk);
  endtask
  task automatic hall_fault(input logic [2:0] v);
    @(posedge pclk);
    hall_in <= v;
    repeat (8) @(posedge pclk);
    hall_in <= hall_tab[hp];
    repeat (8) @(posedge pclk);
  endtask
  // b lags a when stepping up
  task automatic enc_step(input logic up);
    @(posedge pclk);
    qp = up ? qp + 2'h1 : qp - 2'h1;
    enc_phase_a <= qp[1] ^ qp[0];
    enc_phase_b <= qp[1];
    repeat (8) @(posedge pclk);
  endtask
  task automatic index_pulse();
    @(posedge pclk);
    enc_index <= 1'b1;
    repeat (4) @(posedge pclk);
    enc_index <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// File: tb/tb_top.sv
// Purpose: self-checking bench for rotor sensing
// Assumes: apb master here, motor in its own model
// Notes: hall timer shortened to 8 bits
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, count_direction_flag, err;
  logic [15:0] rotor_angle, sec;
  logic [2:0] hall_in;
  logic enc_phase_a, enc_phase_b, enc_index;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  initial forever #50 pclk = ~pclk;
  hqs_rotor_sense #(.TMR_W(8), .CNT_W(16)) i_hqs_rotor_sense (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hall_in(hall_in), .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b),
    .enc_index(enc_index), .irq(irq), .rotor_angle(rotor_angle), .count_direction_flag(count_direction_flag));
  hqs_motor_model i_hqs_motor_model (.pclk(pclk), .hall_in(hall_in), .enc_phase_a(enc_phase_a),
    .enc_phase_b(enc_phase_b), .enc_index(enc_index));
  task automatic end_sim();
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("maxcnt", 32'h0000_0FFF, rd)
    apb(1'b0, 12'h018, 32'h0);
    `CHK("qcount", 32'h0, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_hall();
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    // a long first sector keeps the integral below the sector cap
    repeat (16) @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      i_hqs_motor_model.hall_step();
      sec = 16'(i_hqs_motor_model.hp * 16'h2AAB);
      // small guard absorbs rounding of the sector angle
      `CHK("angle", 1'b1, 16'(rotor_angle - sec + 16'h0010) < 16'h2AAB)
      apb(1'b0, 12'h01C, 32'h0);
      `CHK("hall", {29'h0, hall_in}, rd)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("edge", 32'h1, rd & 32'h7)
    end
    i_hqs_motor_model.hall_fault(3'h0);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("fault0", 32'h4, rd & 32'h4)
    i_hqs_motor_model.hall_fault(3'h7);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("fault7", 32'h4, rd & 32'h4)
    repeat (400) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("ovf", 32'h2, rd & 32'h2)
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b0, 12'h008, 32'h0);
    i_hqs_motor_model.hall_step();
    apb(1'b0, 12'h008, 32'h0);
    `CHK("xor_edge", 32'h1, rd & 32'h1)
  endtask
  task automatic t_irq();
    apb(1'b1, 12'h00C, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    i_hqs_motor_model.hall_step();
    `CHK("irq_on", 1'b1, irq)
    apb(1'b0, 12'h008, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("irq_off", 1'b0, irq)
    apb(1'b1, 12'h00C, 32'h0);
    i_hqs_motor_model.hall_step();
    `CHK("irq_mask", 1'b0, irq)
  endtask
  task automatic t_enc();
    apb(1'b1, 12'h000, 32'h2);
    for (int i = 0; i < 8; i++) i_hqs_motor_model.enc_step(1'b1);
    clk_en <= 1'b0;
    i_hqs_motor_model.enc_step(1'b1);
    clk_en <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, 12'h018, 32'h0);
    `CHK("up", 32'h9, rd)
    `CHK("dir_up", 1'b0, count_direction_flag)
    `CHK("enc_angle", 16'h0090, rotor_angle)
    apb(1'b0, 12'h014, 32'h0);
    `CHK("enc_speed", 1'b1, rd != 32'h0)
    for (int i = 0; i < 11; i++) i_hqs_motor_model.enc_step(1'b0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK("wrap", 32'h0000_0FFE, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("pos_dir", 1'b1, rd[16])
    `CHK("dir_dn", 1'b1, count_direction_flag)
    apb(1'b0, 12'h008, 32'h0);
    i_hqs_motor_model.index_pulse();
    apb(1'b0, 12'h008, 32'h0);
    `CHK("idx_err", 32'h18, rd & 32'h18)
    i_hqs_motor_model.enc_step(1'b1);
    i_hqs_motor_model.enc_step(1'b1);
    i_hqs_motor_model.index_pulse();
    apb(1'b0, 12'h008, 32'h0);
    `CHK("idx_ok", 32'h10, rd & 32'h18)
    apb(1'b1, 12'h000, 32'hA);
    i_hqs_motor_model.enc_step(1'b1);
    apb(1'b0, 12'h018, 32'h0);
    `CHK("filt", 32'h1, rd)
    // inverting both phases is a half-cycle shift: direction is kept
    apb(1'b1, 12'h000, 32'h3A);
    i_hqs_motor_model.enc_step(1'b1);
    apb(1'b0, 12'h018, 32'h0);
    `CHK("inv", 32'h2, rd)
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_hall();
    t_irq();
    t_enc();
    end_sim();
  end
endmodule
